/* core/pid_switchover.sv */
// Loop switchover, output suspension and monitor selection supervisor
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module pid_switchover
   import pid_sw_pkg::*;
#(
   parameter int UNIT_CYCLES = DETECT_UNIT_CYCLES
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Drive side, frequencies in 0.1 Hz
   input wire logic startCmd,
   input wire logic [15:0] outFreq,
   input wire logic [15:0] normalFreq,
   input wire logic [15:0] pidFreq,
   // Process values in 0.1 percent
   input wire logic [15:0] setPointIn,
   input wire logic [15:0] measuredIn,
   input wire logic [15:0] auxIn,
   // Input terminals
   input wire logic loopSelect,
   input wire logic speedSelHigh,
   input wire logic speedSelMid,
   input wire logic speedSelLow,
   input wire logic jogCmd,
   // Outputs
   output logic [15:0] freqCmd,
   output logic pidRestart,
   output logic remoteEnable,
   output status_t statusTerm,
   output logic [15:0] pulseMonitor,
   output logic [15:0] analogMonitor
);

   function automatic logic [15:0] clampFreq(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
      clampFreq = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clampFreq

   function automatic logic [15:0] monValue(input logic [7:0] code,
      input logic allowDev, input logic devIn, input logic [15:0] sp,
      input logic [15:0] meas, input logic [15:0] dev);
      monValue = 16'h0000;
      if (code == CODE_SET && !devIn)
      begin
         monValue = sp;
      end
      else if (code == CODE_MEAS && !devIn)
      begin
         monValue = meas;
      end
      else if (code == CODE_DEV && allowDev)
      begin
         monValue = dev;
      end
   endfunction : monValue

   function automatic logic termLevel(input logic active,
      input logic [7:0] code);
      termLevel = (code >= INVERT_CODE) ? !active : active;
   endfunction : termLevel

   // Registers
   logic [15:0] swFreq_q, swFreq_d, detTime_q, detTime_d;
   logic [15:0] detLevel_q, detLevel_d, cancel_q, cancel_d;
   logic [31:0] action_q, action_d, biasGain_q, biasGain_d;
   logic [31:0] limits_q, limits_d, monSel_q, monSel_d, outFn_q, outFn_d;
   logic [31:0] rdData_q, rdData_d;
   logic err_q, err_d;
   logic wrEn, setup, mapped;
   logic [7:0] actSel, opMode, measAssign, auxAssign;
   logic [7:0] dispSel, pulseSel, analogSel;

   // Supervisor state
   state_t state_q, state_d;
   logic [15:0] freqCmd_q, freqCmd_d;
   logic pidRestart_q, pidRestart_d;
   status_t status_q, status_d;
   logic [15:0] monVal_q, monVal_d, pulseMon_q, pulseMon_d;
   logic [15:0] analogMon_q, analogMon_d;

   // Derived values
   logic loopEnable, devInput, addAux, closedLoop, suspendArm, expired;
   logic cancelHit, overrideCmd;
   logic [15:0] spEff, devMon, loopFreq, normFreq;
   logic signed [17:0] devVal, cancelThr;

   assign actSel = action_q[ACT_SEL_LSB +: 8];
   assign opMode = action_q[MODE_LSB +: 8];
   assign measAssign = action_q[MEAS_ASSIGN_LSB +: 8];
   assign auxAssign = action_q[AUX_ASSIGN_LSB +: 8];
   assign dispSel = monSel_q[MON_DISP_LSB +: 8];
   assign pulseSel = monSel_q[MON_PULSE_LSB +: 8];
   assign analogSel = monSel_q[MON_ANALOG_LSB +: 8];

   assign devInput = (actSel == ACT_DEVIN_A) || (actSel == ACT_DEVIN_B);
   assign addAux = (actSel == ACT_ADD_A) || (actSel == ACT_ADD_B);
   assign spEff = addAux ? 16'(setPointIn + auxIn) : setPointIn;
   assign devVal = $signed({2'b00, spEff}) - $signed({2'b00, measuredIn});
   assign devMon = 16'(devVal + $signed({2'b00, DEV_OFFSET}));
   assign cancelThr = $signed({2'b00, cancel_q})
      - $signed({2'b00, DEV_OFFSET});
   assign cancelHit = (devVal >= cancelThr);

   assign overrideCmd = speedSelHigh || speedSelMid || speedSelLow || jogCmd;
   assign loopEnable = loopSelect && !overrideCmd
      && (opMode != MODE_SWITCHOVER)
      && (measAssign == 8'h00) && (auxAssign == 8'h00);
   assign closedLoop = (state_q == ST_LOOP) || (state_q == ST_SLEEP);

   assign loopFreq = clampFreq(clampFreq(pidFreq, biasGain_q[LO_LSB +: 16],
      biasGain_q[HI_LSB +: 16]), limits_q[HI_LSB +: 16],
      limits_q[LO_LSB +: 16]);
   assign normFreq = clampFreq(normalFreq, limits_q[HI_LSB +: 16],
      limits_q[LO_LSB +: 16]);
   assign suspendArm = (state_q == ST_LOOP) && (loopFreq < detLevel_q)
      && (detTime_q != DISABLE_VALUE);

   suspend_timer #(
      .UNIT_CYCLES(UNIT_CYCLES)
   ) suspend_timer_inst (
      .mclk(mclk),
      .rst(rst),
      .arm(suspendArm),
      .limit(detTime_q),
      .expired(expired)
   );

   // APB decode
   assign setup = psel && !penable;
   assign wrEn = psel && penable && pwrite;
   assign pready = 1'b1;
   assign prdata = rdData_q;
   assign pslverr = err_q;
   assign mapped = (paddr == ADDR_SWFREQ) || (paddr == ADDR_DETTIME)
      || (paddr == ADDR_DETLEVEL) || (paddr == ADDR_CANCEL)
      || (paddr == ADDR_ACTION) || (paddr == ADDR_BIASGAIN)
      || (paddr == ADDR_LIMITS) || (paddr == ADDR_MONSEL)
      || (paddr == ADDR_OUTFN) || (paddr == ADDR_STATUS)
      || (paddr == ADDR_MONVAL);

   always_comb
   begin
      swFreq_d = swFreq_q;
      detTime_d = detTime_q;
      detLevel_d = detLevel_q;
      cancel_d = cancel_q;
      action_d = action_q;
      biasGain_d = biasGain_q;
      limits_d = limits_q;
      monSel_d = monSel_q;
      outFn_d = outFn_q;
      rdData_d = rdData_q;
      err_d = err_q;
      if (setup)
      begin
         err_d = !mapped;
         unique case (paddr)
            ADDR_SWFREQ: rdData_d = {16'h0000, swFreq_q};
            ADDR_DETTIME: rdData_d = {16'h0000, detTime_q};
            ADDR_DETLEVEL: rdData_d = {16'h0000, detLevel_q};
            ADDR_CANCEL: rdData_d = {16'h0000, cancel_q};
            ADDR_ACTION: rdData_d = action_q;
            ADDR_BIASGAIN: rdData_d = biasGain_q;
            ADDR_LIMITS: rdData_d = limits_q;
            ADDR_MONSEL: rdData_d = monSel_q;
            ADDR_OUTFN: rdData_d = outFn_q;
            ADDR_STATUS: rdData_d = {26'h0, state_q, status_q};
            ADDR_MONVAL: rdData_d = {16'h0000, monVal_q};
            default: rdData_d = 32'h0000_0000;
         endcase
      end
      if (wrEn)
      begin
         unique case (paddr)
            ADDR_SWFREQ:
            begin
               if (pwdata[15:0] <= SWFREQ_MAX
                  || pwdata[15:0] == DISABLE_VALUE)
               begin
                  swFreq_d = pwdata[15:0];
               end
            end
            ADDR_DETTIME: detTime_d = pwdata[15:0];
            ADDR_DETLEVEL: detLevel_d = pwdata[15:0];
            ADDR_CANCEL: cancel_d = pwdata[15:0];
            ADDR_ACTION: action_d = pwdata;
            ADDR_BIASGAIN: biasGain_d = pwdata;
            ADDR_LIMITS: limits_d = pwdata;
            ADDR_MONSEL:
            begin
               monSel_d[MON_DISP_LSB +: 8] = pwdata[MON_DISP_LSB +: 8];
               if (pwdata[MON_PULSE_LSB +: 8] != CODE_DEV)
               begin
                  monSel_d[MON_PULSE_LSB +: 8] =
                     pwdata[MON_PULSE_LSB +: 8];
               end
               if (pwdata[MON_ANALOG_LSB +: 8] != CODE_DEV)
               begin
                  monSel_d[MON_ANALOG_LSB +: 8] =
                     pwdata[MON_ANALOG_LSB +: 8];
               end
            end
            ADDR_OUTFN: outFn_d = pwdata;
            default: rdData_d = rdData_q;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         swFreq_q <= RST_SWFREQ;
         detTime_q <= RST_DETTIME;
         detLevel_q <= RST_DETLEVEL;
         cancel_q <= RST_CANCEL;
         action_q <= RST_ACTION;
         biasGain_q <= RST_BIASGAIN;
         limits_q <= RST_LIMITS;
         monSel_q <= RST_MONSEL;
         outFn_q <= RST_OUTFN;
         rdData_q <= 32'h0000_0000;
         err_q <= 1'b0;
      end
      else
      begin
         swFreq_q <= swFreq_d;
         detTime_q <= detTime_d;
         detLevel_q <= detLevel_d;
         cancel_q <= cancel_d;
         action_q <= action_d;
         biasGain_q <= biasGain_d;
         limits_q <= limits_d;
         monSel_q <= monSel_d;
         outFn_q <= outFn_d;
         rdData_q <= rdData_d;
         err_q <= err_d;
      end
   end

   // Supervisor next state and outputs
   always_comb
   begin
      state_d = state_q;
      pidRestart_d = 1'b0;
      if (!startCmd)
      begin
         state_d = ST_IDLE;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               if (!loopEnable)
               begin
                  state_d = ST_NORMAL;
               end
               else if (swFreq_q == DISABLE_VALUE)
               begin
                  state_d = ST_LOOP;
               end
               else
               begin
                  state_d = ST_OPEN;
               end
            end
            ST_NORMAL:
            begin
               if (loopEnable)
               begin
                  state_d = ST_LOOP;
                  pidRestart_d = 1'b1;
               end
            end
            ST_OPEN:
            begin
               if (!loopEnable)
               begin
                  state_d = ST_NORMAL;
               end
               else if (outFreq >= swFreq_q)
               begin
                  state_d = ST_LOOP;
               end
            end
            ST_LOOP:
            begin
               if (!loopEnable)
               begin
                  state_d = ST_NORMAL;
               end
               else if (expired)
               begin
                  state_d = ST_SLEEP;
               end
            end
            ST_SLEEP:
            begin
               if (!loopEnable)
               begin
                  state_d = ST_NORMAL;
               end
               else if (cancelHit)
               begin
                  state_d = ST_LOOP;
               end
            end
            default: state_d = ST_IDLE;
         endcase
      end
      unique case (state_d)
         ST_NORMAL, ST_OPEN: freqCmd_d = normFreq;
         ST_LOOP: freqCmd_d = pidRestart_d ? 16'h0000 : loopFreq;
         default: freqCmd_d = 16'h0000;
      endcase
      status_d.run = (state_d != ST_IDLE) && (state_d != ST_SLEEP);
      status_d.loopActive = (state_d == ST_LOOP)
         || (state_d == ST_SLEEP);
      status_d.suspended = (state_d == ST_SLEEP)
         && (detTime_q != DISABLE_VALUE);
      monVal_d = monValue(dispSel, 1'b1, devInput, spEff, measuredIn,
         devMon);
      pulseMon_d = monValue(pulseSel, 1'b0, devInput, spEff, measuredIn,
         devMon);
      analogMon_d = monValue(analogSel, 1'b0, devInput, spEff, measuredIn,
         devMon);
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         freqCmd_q <= 16'h0000;
         pidRestart_q <= 1'b0;
         status_q <= '0;
         monVal_q <= 16'h0000;
         pulseMon_q <= 16'h0000;
         analogMon_q <= 16'h0000;
      end
      else
      begin
         state_q <= state_d;
         freqCmd_q <= freqCmd_d;
         pidRestart_q <= pidRestart_d;
         status_q <= status_d;
         monVal_q <= monVal_d;
         pulseMon_q <= pulseMon_d;
         analogMon_q <= analogMon_d;
      end
   end

   assign freqCmd = freqCmd_q;
   assign pidRestart = pidRestart_q;
   assign remoteEnable = !closedLoop;
   assign pulseMonitor = pulseMon_q;
   assign analogMonitor = analogMon_q;
   assign statusTerm = {
      termLevel(status_q.run, outFn_q[OUTFN_RUN_LSB +: 8]),
      termLevel(status_q.loopActive, outFn_q[OUTFN_LOOP_LSB +: 8]),
      termLevel(status_q.suspended, outFn_q[OUTFN_SLEEP_LSB +: 8])};

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   chk_switch_at_freq: assert property (
      state_q == ST_OPEN && startCmd && loopEnable && outFreq >= swFreq_q
      |=> state_q == ST_LOOP)
      else $error("no switchover at frequency");
   chk_loop_holds: assert property (
      state_q == ST_LOOP && startCmd && loopEnable
      |=> state_q == ST_LOOP || state_q == ST_SLEEP)
      else $error("closed loop left while enabled");
   chk_sleep_entry: assert property (
      state_q == ST_LOOP && startCmd && loopEnable && expired
      |=> state_q == ST_SLEEP && !status_q.run)
      else $error("suspension not entered");
   chk_wake_up: assert property (
      state_q == ST_SLEEP && startCmd && loopEnable && cancelHit
      |=> state_q == ST_LOOP && status_q.run)
      else $error("suspension not cancelled");
   chk_sleep_status: assert property (
      state_q == ST_SLEEP |-> !status_q.run && status_q.loopActive
      && (status_q.suspended == (detTime_q != DISABLE_VALUE)))
      else $error("status wrong while suspended");
   chk_no_analog_dev: assert property (
      pulseSel != CODE_DEV && analogSel != CODE_DEV)
      else $error("deviation code on terminal selector");
   chk_devin_zero: assert property (
      devInput && (dispSel == CODE_SET || dispSel == CODE_MEAS)
      |=> monVal_q == 16'h0000)
      else $error("set or measured monitor not zero");
   chk_interlock: assert property (
      startCmd && !loopEnable && state_q != ST_IDLE
      |=> state_q == ST_NORMAL)
      else $error("closed loop not stopped by interlock");
   chk_remote_off: assert property (
      status_q.loopActive |-> !remoteEnable)
      else $error("remote setting active in closed loop");
   chk_zero_base: assert property (
      state_q == ST_NORMAL && startCmd && loopEnable
      |=> pidRestart_q && freqCmd_q == 16'h0000 ##1 !pidRestart_q)
      else $error("loop entry not from zero base");
   chk_bypass_switch: assert property (
      state_q == ST_IDLE && startCmd && loopEnable
      && swFreq_q == DISABLE_VALUE |=> state_q == ST_LOOP)
      else $error("disabled switchover not bypassed");

endmodule : pid_switchover

/* core/pid_sw_pkg.sv */
// Constants, types and register map of the loop supervisor
package pid_sw_pkg;

   // Register byte offsets
   localparam logic [7:0] ADDR_SWFREQ = 8'h00;
   localparam logic [7:0] ADDR_DETTIME = 8'h04;
   localparam logic [7:0] ADDR_DETLEVEL = 8'h08;
   localparam logic [7:0] ADDR_CANCEL = 8'h0C;
   localparam logic [7:0] ADDR_ACTION = 8'h10;
   localparam logic [7:0] ADDR_BIASGAIN = 8'h14;
   localparam logic [7:0] ADDR_LIMITS = 8'h18;
   localparam logic [7:0] ADDR_MONSEL = 8'h1C;
   localparam logic [7:0] ADDR_OUTFN = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;
   localparam logic [7:0] ADDR_MONVAL = 8'h28;

   // Field positions
   localparam int ACT_SEL_LSB = 0;
   localparam int MODE_LSB = 8;
   localparam int MEAS_ASSIGN_LSB = 16;
   localparam int AUX_ASSIGN_LSB = 24;
   localparam int LO_LSB = 0;
   localparam int HI_LSB = 16;
   localparam int MON_DISP_LSB = 0;
   localparam int MON_PULSE_LSB = 8;
   localparam int MON_ANALOG_LSB = 16;
   localparam int OUTFN_LOOP_LSB = 0;
   localparam int OUTFN_SLEEP_LSB = 8;
   localparam int OUTFN_RUN_LSB = 16;

   // Special values and codes
   localparam logic [15:0] DISABLE_VALUE = 16'h270F;
   localparam logic [15:0] SWFREQ_MAX = 16'h0FA0;
   localparam logic [15:0] DEV_OFFSET = 16'h03E8;
   localparam logic [7:0] CODE_SET = 8'h34;
   localparam logic [7:0] CODE_MEAS = 8'h35;
   localparam logic [7:0] CODE_DEV = 8'h36;
   localparam logic [7:0] ACT_DEVIN_A = 8'h0A;
   localparam logic [7:0] ACT_DEVIN_B = 8'h0B;
   localparam logic [7:0] ACT_ADD_A = 8'h14;
   localparam logic [7:0] ACT_ADD_B = 8'h15;
   localparam logic [7:0] MODE_SWITCHOVER = 8'h06;
   localparam logic [7:0] INVERT_CODE = 8'h64;

   // Reset values
   localparam logic [15:0] RST_SWFREQ = DISABLE_VALUE;
   localparam logic [15:0] RST_DETTIME = DISABLE_VALUE;
   localparam logic [15:0] RST_DETLEVEL = 16'h0000;
   localparam logic [15:0] RST_CANCEL = 16'h03E8;
   localparam logic [31:0] RST_ACTION = 32'h0000_0000;
   localparam logic [31:0] RST_BIASGAIN = 32'h0258_0000;
   localparam logic [31:0] RST_LIMITS = 32'h0000_04B0;
   localparam logic [31:0] RST_MONSEL = 32'h0000_0000;
   localparam logic [31:0] RST_OUTFN = 32'h0000_462F;

   // Timing: detection time counts in units of 0.1 s
   localparam int DETECT_UNIT_NS = 100000000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int DETECT_UNIT_CYCLES = DETECT_UNIT_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_NORMAL = 3'b001,
      ST_OPEN = 3'b010,
      ST_LOOP = 3'b011,
      ST_SLEEP = 3'b100
   } state_t;

   typedef struct packed {
      logic run;
      logic loopActive;
      logic suspended;
   } status_t;

endpackage : pid_sw_pkg

/* core/suspend_timer.sv */
// Low-frequency dwell timer for output suspension
`timescale 1ns/1ns
module suspend_timer
   import pid_sw_pkg::*;
#(
   parameter int UNIT_CYCLES = DETECT_UNIT_CYCLES
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Control
   input wire logic arm,
   input wire logic [15:0] limit,
   output logic expired
);

   logic [31:0] prescale_q, prescale_d;
   logic [15:0] units_q, units_d;
   logic unitTick;

   assign unitTick = (prescale_q == 32'(UNIT_CYCLES - 1));
   assign expired = arm && (units_q >= limit);

   always_comb
   begin
      prescale_d = prescale_q;
      units_d = units_q;
      if (!arm)
      begin
         prescale_d = 32'h0000_0000;
         units_d = 16'h0000;
      end
      else if (unitTick)
      begin
         prescale_d = 32'h0000_0000;
         if (units_q != 16'hFFFF)
         begin
            units_d = units_q + 16'h0001;
         end
      end
      else
      begin
         prescale_d = prescale_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         prescale_q <= 32'h0000_0000;
         units_q <= 16'h0000;
      end
      else
      begin
         prescale_q <= prescale_d;
         units_q <= units_d;
      end
   end

endmodule : suspend_timer

/* tb/drive_plant.sv */
// Drive output stage model: output frequency slews toward the command
`timescale 1ns/1ns
module drive_plant
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Command in, actual frequency out
   input wire logic [15:0] freqCmd,
   output logic [15:0] outFreq
);
   logic [15:0] slew_q;
   logic [15:0] slew_d;

   // One step of 0.1 Hz per cycle, like a real ramp
   always_comb
   begin
      slew_d = slew_q;
      if (slew_q < freqCmd)
         slew_d = slew_q + 16'h0001;
      else if (slew_q > freqCmd)
         slew_d = slew_q - 16'h0001;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         slew_q <= 16'h0000;
      else
         slew_q <= slew_d;
   end

   assign outFreq = slew_q;
endmodule : drive_plant

/* tb/pid_switchover_test.sv */
// Self-checking bench for the loop supervisor
`timescale 1ns/1ns
module pid_switchover_test;
   import pid_sw_pkg::*;
   logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic pready, pslverr, pidRestart, remoteEnable;
   logic startCmd = 0, loopSelect = 0, portReq = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [15:0] outFreq, freqCmd, pulseMonitor, analogMonitor, sp;
   logic [15:0] normalFreq = 0, pidFreq = 0, setPointIn = 0;
   logic [15:0] measuredIn = 0, auxIn = 0;
   logic [3:0] speedJog = 0;
   logic [32:0] portVal = 0;
   logic [32:0] expQ[$];
   status_t statusTerm;
   int fails = 0, checked = 0, i;
   integer seed = 32'h959d;

   pid_switchover #(.UNIT_CYCLES(10)) pid_switchover_inst (.mclk(mclk),
      .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .startCmd(startCmd), .outFreq(outFreq),
      .normalFreq(normalFreq), .pidFreq(pidFreq), .setPointIn(setPointIn),
      .measuredIn(measuredIn), .auxIn(auxIn), .loopSelect(loopSelect),
      .speedSelHigh(speedJog[3]), .speedSelMid(speedJog[2]),
      .speedSelLow(speedJog[1]), .jogCmd(speedJog[0]), .freqCmd(freqCmd),
      .pidRestart(pidRestart), .remoteEnable(remoteEnable),
      .statusTerm(statusTerm), .pulseMonitor(pulseMonitor),
      .analogMonitor(analogMonitor));

   drive_plant drive_plant_inst (.mclk(mclk), .rst(rst),
      .freqCmd(freqCmd), .outFreq(outFreq));

   always #50 mclk = ~mclk;

   task check(input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task results;
      if (fails == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results

   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : xfer

   task rd(input logic [7:0] a, input logic [32:0] exp);
      expQ.push_back(exp);
      xfer(a, 1'b0, 32'h00000000);
   endtask : rd

   task pc(input logic [32:0] seen, input logic [32:0] exp);
      expQ.push_back(exp);
      portVal <= seen;
      portReq <= 1'b1;
      @(posedge mclk);
      portReq <= 1'b0;
   endtask : pc

   task wt(input int n);
      repeat (n) @(posedge mclk);
   endtask : wt

   // Result watcher
   always @(posedge mclk)
      if (psel && penable && pready && !pwrite)
         check({pslverr, prdata}, expQ.pop_front());
      else if (portReq)
         check(portVal, expQ.pop_front());

   initial
   begin
      #5000000;
      fails++;
      results();
   end

   initial
   begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      rd(ADDR_SWFREQ, 33'h0270F);
      rd(ADDR_CANCEL, 33'h003E8);
      rd(8'h2C, 33'h100000000);
      xfer(ADDR_SWFREQ, 1'b1, 32'h00000FA1);
      rd(ADDR_SWFREQ, 33'h0270F);
      xfer(ADDR_SWFREQ, 1'b1, 32'h000001F4);
      xfer(ADDR_BIASGAIN, 1'b1, 32'h02580010);
      rd(ADDR_BIASGAIN, 33'h002580010);
      normalFreq <= 16'h0258;
      pidFreq <= 16'h02BC;
      loopSelect <= 1'b1;
      startCmd <= 1'b1;
      wt(3);
      rd(ADDR_STATUS, 33'h00014);
      for (i = 0; i < 1000 && statusTerm.loopActive !== 1'b1; i++)
         @(posedge mclk);
      wt(3);
      pc({17'h0, freqCmd}, 33'h00258);
      pidFreq <= 16'h0032;
      wt(600);
      rd(ADDR_STATUS, 33'h0001E);
      pc({32'h0, remoteEnable}, 33'h0);
      // Sleep with deviation below the cancel level
      setPointIn <= 16'h01F4;
      measuredIn <= 16'h0258;
      xfer(ADDR_DETLEVEL, 1'b1, 32'h00000064);
      xfer(ADDR_DETTIME, 1'b1, 32'h00000002);
      for (i = 0; i < 1000 && statusTerm.suspended !== 1'b1; i++)
         @(posedge mclk);
      wt(2);
      rd(ADDR_STATUS, 33'h00023);
      pc({17'h0, freqCmd}, 33'h0);
      // Wake on a random deviation above the cancel level
      sp = 16'h0258 + {8'h00, 8'($random(seed))};
      auxIn <= {10'h000, 6'($random(seed))};
      pidFreq <= 16'h012C;
      setPointIn <= sp;
      measuredIn <= 16'h0064;
      wt(3);
      rd(ADDR_STATUS, 33'h0001E);
      xfer(ADDR_MONSEL, 1'b1, 32'h00363636);
      rd(ADDR_MONSEL, 33'h00036);
      rd(ADDR_MONVAL, {17'h0, sp + 16'h0384});
      xfer(ADDR_MONSEL, 1'b1, 32'h00353534);
      wt(2);
      pc({17'h0, pulseMonitor}, 33'h00064);
      pc({17'h0, analogMonitor}, 33'h00064);
      rd(ADDR_MONVAL, {17'h0, sp});
      xfer(ADDR_MONSEL, 1'b1, 32'h00363634);
      rd(ADDR_MONSEL, 33'h000353534);
      xfer(ADDR_ACTION, 1'b1, 32'h00000014);
      wt(2);
      rd(ADDR_MONVAL, {17'h0, sp + auxIn});
      xfer(ADDR_ACTION, 1'b1, 32'h0000000A);
      wt(2);
      rd(ADDR_MONVAL, 33'h0);
      xfer(ADDR_ACTION, 1'b1, 32'h00000000);
      for (i = 0; i < 4; i++)
      begin
         speedJog <= 4'h1 << i;
         wt(3);
         rd(ADDR_STATUS, 33'h0000C);
         speedJog <= 4'h0;
         wt(2);
         pc({16'h0, pidRestart, freqCmd}, 33'h10000);
         rd(ADDR_STATUS, 33'h0001E);
      end
      for (i = 0; i < 3; i++)
      begin
         xfer(ADDR_ACTION, 1'b1, 32'h00000600 << (i * 8));
         wt(2);
         rd(ADDR_STATUS, 33'h0000C);
      end
      pc({30'h0, statusTerm}, 33'h00004);
      xfer(ADDR_OUTFN, 1'b1, 32'h0064462F);
      wt(2);
      pc({30'h0, statusTerm}, 33'h0);
      results();
   end
endmodule : pid_switchover_test
